/* File: common/sac_pkg.sv */
package sac_pkg;
    // =========================================================
    // Register bus
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam logic [15:0] OFF_RESULT_LOW = 16'h006F;
    localparam logic [15:0] OFF_RESULT_HIGH = 16'h0070;
    localparam logic [15:0] OFF_CONTROL_STATUS = 16'h0071;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // =========================================================
    // Control/status fields and reset values
    localparam int CSR_DONE_BIT = 7;
    localparam int CSR_SPEED_BIT = 6;
    localparam int CSR_ON_BIT = 5;
    localparam int CSR_SLOW_BIT = 4;
    localparam int CSR_CHAN_MSB = 2;
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam logic [7:0] RESULT_HIGH_RESET = 8'h00;
    localparam logic [1:0] RESULT_LOW_RESET = 2'h0;
    localparam logic [5:0] RESULT_LOW_PAD = 6'h00;
    localparam logic [2:0] CHAN_LAST = 3'h5;

    // =========================================================
    // Conversion
    localparam int RES_W = 10;
    localparam logic [3:0] BIT_FIRST = 4'h9;
    localparam logic [9:0] CODE_ONE = 10'h001;
    localparam logic [9:0] CODE_MID = 10'h200;
    localparam logic [2:0] SAMPLE_TICKS = 3'h4;
    localparam logic [2:0] BIT_TICKS = 3'h6;

    // =========================================================
    // Clock prescaler: {slow, speed}
    localparam logic [1:0] SEL_FULL = 2'h1;
    localparam logic [1:0] SEL_QUARTER = 2'h2;
    localparam logic [1:0] DIV_FULL_LIM = 2'h0;
    localparam logic [1:0] DIV_HALF_LIM = 2'h1;
    localparam logic [1:0] DIV_QUARTER_LIM = 2'h3;

    // =========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int STAB_TIME_NS = 20000;
    localparam int STAB_CYCLES_INT = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] STAB_CYCLES = 10'(STAB_CYCLES_INT);

    // =========================================================
    // State
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_SAMPLE,
        PH_BITS
    } sac_phase_t;

    typedef struct packed {
        logic [1:0] cnt;
        logic tick;
    } sac_div_state_t;

    typedef struct packed {
        sac_phase_t phase;
        logic [2:0] tickCnt;
        logic [3:0] bitIdx;
        logic [9:0] code;
        logic sample;
        logic done;
        logic speed;
        logic on;
        logic slow;
        logic [2:0] chan;
        logic [7:0] resHigh;
        logic [1:0] resLow;
        logic lock;
        logic [7:0] rdData;
        logic powerOn;
        logic [9:0] stabCnt;
        logic stable;
        logic cmpS1;
        logic cmpS2;
        logic cmpS3;
        logic cmpStable;
    } sac_ctrl_state_t;
endpackage

/* File: rtl/sac_clock_div.sv */
`timescale 1ns/10ps
module sac_clock_div (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic [1:0] sel,
    output logic tick
);
    import sac_pkg::*;

    sac_div_state_t st_reg;
    sac_div_state_t st_next;
    logic [1:0] lim;

    // =========================================================
    // Divide by 1, 2 or 4
    always_comb begin
        st_next = st_reg;
        unique case (sel)
            SEL_FULL: lim = DIV_FULL_LIM;
            SEL_QUARTER: lim = DIV_QUARTER_LIM;
            default: lim = DIV_HALF_LIM;
        endcase
        if (!run) begin
            st_next.cnt = 2'h0;
            st_next.tick = 1'b0;
        end else if (st_reg.cnt >= lim) begin
            st_next.cnt = 2'h0;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 2'h1;
            st_next.tick = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick = st_reg.tick;

    // =========================================================
    // Checks
    chk_quarter_rate: assert property (@(posedge core_clk) disable iff (sys_rst)
        run && tick && sel == SEL_QUARTER && $stable(sel) |=> !tick ##1 !tick ##1 !tick)
        else $error("quarter rate tick too early");
    chk_full_rate: assert property (@(posedge core_clk) disable iff (sys_rst)
        run && $past(run) && sel == SEL_FULL && $past(sel) == SEL_FULL |-> tick)
        else $error("full rate tick missing");
endmodule

/* File: rtl/sac_control.sv */
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
// Function
// - Converter on: convert selected channel again and again until switched off.
// - Each finished conversion stores result and sets done flag in bit 7.
// - Reading high result or writing control/status clears the done flag.
// - Reading low result freezes high result until high result is read.
// - Input above upper reference reads FFh high, 03h low, no overflow flag.
// - Input below lower reference reads zero in both result registers.
// - Slow/fast select: 01 full clock, 11 and 00 half, 10 quarter.
// - Bit 5 on starts conversion; off stops it.
// - Channel field bits 2:0 selects analog input n; codes 0 to 5 valid.
// - High result holds bits 9:2; low holds bits 1:0, upper bits zero.
// - Done flag bit 7 read-only; bit 3 reads zero; bits 6:4 and 2:0 read and write.
// - Control/status and both result registers reset to zero.
// - Result never falls with non-falling input, never rises with non-rising.
// - Idle-sleep mode leaves converter running.
// - Deep-stop disables converter; results need a settling wait after wakeup.
module sac_control (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [sac_pkg::ADDR_W-1:0] busAddr,
    input wire logic [sac_pkg::DATA_W-1:0] busWrData,
    input wire logic busWrEn,
    input wire logic busRdEn,
    output logic [sac_pkg::DATA_W-1:0] busRdData,
    input wire logic cmpAbove,
    input wire logic deepStop,
    output logic converterOn,
    output logic [2:0] channelSelect,
    output logic sampleHold,
    output logic [sac_pkg::RES_W-1:0] dacCode,
    output logic resultsStable
);
    import sac_pkg::*;

    sac_ctrl_state_t st_reg;
    sac_ctrl_state_t st_next;
    logic adcTick;
    logic active;
    logic rdHigh;
    logic rdLow;
    logic rdCsr;
    logic wrCsr;
    logic bitEnd;
    logic doneEvt;
    logic [9:0] bitMask;
    logic [9:0] kept;
    logic [7:0] csrView;

    // =========================================================
    // Converter clock enable
    sac_clock_div u_div (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .run(st_reg.powerOn),
        .sel({st_reg.slow, st_reg.speed}),
        .tick(adcTick)
    );

    // =========================================================
    // Decode and helpers
    assign active = st_reg.on && !deepStop;
    assign rdHigh = busRdEn && busAddr == OFF_RESULT_HIGH;
    assign rdLow = busRdEn && busAddr == OFF_RESULT_LOW;
    assign rdCsr = busRdEn && busAddr == OFF_CONTROL_STATUS;
    assign wrCsr = busWrEn && busAddr == OFF_CONTROL_STATUS;
    assign bitEnd = active && st_reg.phase == PH_BITS && adcTick && st_reg.tickCnt == BIT_TICKS - 3'h1;
    assign doneEvt = bitEnd && st_reg.bitIdx == 4'h0;
    assign bitMask = CODE_ONE << st_reg.bitIdx;
    // Over-range drives all ones, under-range all zeros
    assign kept = st_reg.cmpStable ? st_reg.code : (st_reg.code & ~bitMask);
    assign csrView = {st_reg.done, st_reg.speed, st_reg.on, st_reg.slow, 1'b0, st_reg.chan};

    // =========================================================
    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.rdData = READ_UNMAPPED;

        // Comparator synchroniser, change taken once stages 2 and 3 agree
        st_next.cmpS1 = cmpAbove;
        st_next.cmpS2 = st_reg.cmpS1;
        st_next.cmpS3 = st_reg.cmpS2;
        if (st_reg.cmpS2 == st_reg.cmpS3) begin
            st_next.cmpStable = st_reg.cmpS3;
        end

        // Settling wait after deep-stop
        if (deepStop) begin
            st_next.stabCnt = 10'h000;
            st_next.stable = 1'b0;
        end else if (st_reg.stabCnt != STAB_CYCLES) begin
            st_next.stabCnt = st_reg.stabCnt + 10'h001;
        end else begin
            st_next.stable = 1'b1;
        end

        // Register reads
        if (rdCsr) begin
            st_next.rdData = csrView;
        end
        if (rdHigh) begin
            st_next.rdData = st_reg.resHigh;
            st_next.done = 1'b0;
            st_next.lock = 1'b0;
        end
        if (rdLow) begin
            st_next.rdData = {RESULT_LOW_PAD, st_reg.resLow};
            st_next.lock = 1'b1;
        end

        // Register writes; done flag is not writable
        if (wrCsr) begin
            st_next.done = 1'b0;
            st_next.speed = busWrData[CSR_SPEED_BIT];
            st_next.on = busWrData[CSR_ON_BIT];
            st_next.slow = busWrData[CSR_SLOW_BIT];
            st_next.chan = busWrData[CSR_CHAN_MSB:0];
        end

        // Successive approximation
        if (!active) begin
            st_next.phase = PH_IDLE;
            st_next.sample = 1'b0;
            st_next.tickCnt = 3'h0;
        end else begin
            unique case (st_reg.phase)
                PH_IDLE: begin
                    st_next.phase = PH_SAMPLE;
                    st_next.sample = 1'b1;
                    st_next.tickCnt = 3'h0;
                end
                PH_SAMPLE: begin
                    if (adcTick) begin
                        if (st_reg.tickCnt == SAMPLE_TICKS - 3'h1) begin
                            st_next.phase = PH_BITS;
                            st_next.sample = 1'b0;
                            st_next.tickCnt = 3'h0;
                            st_next.bitIdx = BIT_FIRST;
                            st_next.code = CODE_MID;
                        end else begin
                            st_next.tickCnt = st_reg.tickCnt + 3'h1;
                        end
                    end
                end
                PH_BITS: begin
                    if (adcTick) begin
                        if (bitEnd) begin
                            st_next.tickCnt = 3'h0;
                            if (doneEvt) begin
                                st_next.code = kept;
                                st_next.phase = PH_SAMPLE;
                                st_next.sample = 1'b1;
                            end else begin
                                st_next.bitIdx = st_reg.bitIdx - 4'h1;
                                st_next.code = kept | (bitMask >> 1);
                            end
                        end else begin
                            st_next.tickCnt = st_reg.tickCnt + 3'h1;
                        end
                    end
                end
            endcase
        end

        // Result store; set beats any clear in the same cycle
        if (doneEvt) begin
            // Low read locks at once; a high read in the same cycle unlocks
            st_next.resLow = kept[1:0];
            if (!(st_reg.lock || rdLow) || rdHigh) begin
                st_next.resHigh = kept[9:2];
            end
            st_next.done = 1'b1;
        end

        st_next.powerOn = st_next.on && !deepStop;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // =========================================================
    // Outputs
    assign busRdData = st_reg.rdData;
    assign converterOn = st_reg.powerOn;
    assign channelSelect = st_reg.chan;
    assign sampleHold = st_reg.sample;
    assign dacCode = st_reg.code;
    assign resultsStable = st_reg.stable;

    // =========================================================
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    sequence seq_high_read;
        rdHigh && !doneEvt;
    endsequence

    sequence seq_low_then_idle;
        rdLow ##1 !rdHigh;
    endsequence

    chk_done_set: assert property (doneEvt |=> st_reg.done)
        else $error("done flag not set after conversion");
    chk_done_high_clear: assert property (seq_high_read |=> !st_reg.done)
        else $error("high read did not clear done flag");
    chk_done_write_clear: assert property (wrCsr && !doneEvt |=> !st_reg.done)
        else $error("control write did not clear done flag");
    chk_high_freeze: assert property (seq_low_then_idle |-> $stable(st_reg.resHigh))
        else $error("high result changed while locked");
    chk_high_hold: assert property (st_reg.lock && !rdHigh |=> $stable(st_reg.resHigh))
        else $error("locked high result overwritten");
    chk_off_idle: assert property (!st_reg.on |=> st_reg.phase == PH_IDLE && !sampleHold)
        else $error("converter running while off");
    chk_restart_conv: assert property (doneEvt && st_reg.on && !deepStop |=> st_reg.phase == PH_SAMPLE)
        else $error("no new conversion after completion");
    chk_low_pad: assert property (rdLow |=> busRdData[7:2] == RESULT_LOW_PAD)
        else $error("low result upper bits not zero");
    chk_csr_read: assert property (rdCsr |=> busRdData ==
        {$past(st_reg.done), $past(st_reg.speed), $past(st_reg.on), $past(st_reg.slow), 1'b0, $past(st_reg.chan)})
        else $error("control read wrong");
    chk_reset_zero: assert property ($fell(sys_rst) |-> csrView == CSR_RESET
        && st_reg.resHigh == RESULT_HIGH_RESET && st_reg.resLow == RESULT_LOW_RESET)
        else $error("registers not zero after reset");
    chk_stop_off: assert property (deepStop |=> !converterOn && !resultsStable)
        else $error("converter active in deep-stop");
    chk_saturate: assert property (doneEvt && st_reg.cmpStable && st_reg.code == 10'h3FF |=>
        st_reg.resLow == 2'h3)
        else $error("saturated result wrong");

    // =========================================================
    // Register read data and control writes
    chk_rd_quiet: assert property (!busRdEn |=> busRdData == READ_UNMAPPED)
        else $error("read data outside read cycle");
    chk_high_data: assert property (rdHigh |=> busRdData == $past(st_reg.resHigh))
        else $error("high result read wrong");
    chk_low_data: assert property (rdLow |=> busRdData[1:0] == $past(st_reg.resLow))
        else $error("low result read wrong");
    chk_csr_write: assert property (wrCsr |=> csrView[6:0] ==
        {$past(busWrData[CSR_SPEED_BIT]), $past(busWrData[CSR_ON_BIT]), $past(busWrData[CSR_SLOW_BIT]),
        1'b0, $past(busWrData[CSR_CHAN_MSB:0])})
        else $error("control write not taken");
    chk_chan_out: assert property (wrCsr |=> channelSelect == $past(busWrData[CSR_CHAN_MSB:0]))
        else $error("channel select not driven");

    // =========================================================
    // Conversion steps
    sequence seq_bit_kept;
        bitEnd && st_reg.cmpStable;
    endsequence

    sequence seq_bit_dropped;
        bitEnd && !st_reg.cmpStable;
    endsequence

    sequence seq_conv_begin;
        active && st_reg.phase == PH_IDLE;
    endsequence

    chk_bit_keep: assert property (seq_bit_kept |=> (dacCode & $past(bitMask)) == $past(bitMask))
        else $error("accepted trial bit lost");
    chk_bit_drop: assert property (seq_bit_dropped |=> (dacCode & $past(bitMask)) == 10'h000)
        else $error("rejected trial bit kept");
    chk_next_trial: assert property (bitEnd && !doneEvt |=> (dacCode & ($past(bitMask) >> 1)) != 10'h000)
        else $error("next trial bit not set");
    chk_start_sample: assert property (seq_conv_begin |=> sampleHold && st_reg.tickCnt == 3'h0)
        else $error("conversion did not start sampling");
    chk_first_trial: assert property (active && st_reg.phase == PH_SAMPLE && adcTick
        && st_reg.tickCnt == SAMPLE_TICKS - 3'h1 |=> dacCode == CODE_MID)
        else $error("first trial code wrong");
    chk_cmp_agree: assert property (st_reg.cmpS2 == st_reg.cmpS3 |=> st_reg.cmpStable == $past(st_reg.cmpS3))
        else $error("comparator sync not taken");

    // =========================================================
    // Holding behaviour
    chk_done_stays: assert property (st_reg.done && !rdHigh && !wrCsr |=> st_reg.done)
        else $error("done flag lost without clear");
    chk_low_stays: assert property (!doneEvt |=> $stable(st_reg.resLow))
        else $error("low result changed without conversion");
    chk_result_store: assert property (doneEvt |=> st_reg.resLow == $past(kept[1:0]))
        else $error("low result not stored");
    chk_power_on: assert property (st_reg.on && !deepStop && !wrCsr |=> converterOn)
        else $error("converter power missing");
    chk_deep_abort: assert property (deepStop |=> st_reg.phase == PH_IDLE && !sampleHold)
        else $error("conversion not stopped in deep-stop");
    chk_wake_wait: assert property ($fell(deepStop) |-> !resultsStable ##1 !resultsStable)
        else $error("results marked stable too soon");
    chk_reset_outputs: assert property ($fell(sys_rst) |-> !converterOn && !sampleHold
        && dacCode == 10'h000 && busRdData == READ_UNMAPPED)
        else $error("outputs not idle after reset");
endmodule

/* File: verification/sac_analog_model.sv */
`timescale 1ns/10ps
// ==========================================
// Analog mux, sample/hold and comparator
module sac_analog_model (
    input wire logic core_clk,
    input wire logic converterOn,
    input wire logic [2:0] channelSelect,
    input wire logic sampleHold,
    input wire logic [9:0] dacCode,
    input wire logic [65:0] levels,
    output logic cmpAbove
);
    logic [10:0] held = 11'h000;
    logic toggle = 1'b0;
    always_ff @(posedge core_clk) begin
        toggle <= ~toggle;
        if (sampleHold && channelSelect <= 3'h5) begin
            held <= levels[channelSelect * 11 +: 11];
        end
    end
    // Unpowered or unselected: no stable answer
    // Ideal comparator: settles within one cycle at any converter rate
    assign cmpAbove = (!converterOn || channelSelect > 3'h5) ? toggle
        : ({1'b0, dacCode} <= held);
endmodule

/* File: verification/tb.sv */
`timescale 1ns/10ps
module tb;
    import sac_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] busAddr = 16'h0000;
    logic [7:0] busWrData = 8'h00;
    logic busWrEn = 1'b0;
    logic busRdEn = 1'b0;
    logic deepStop = 1'b0;
    logic [65:0] levels = 66'h0;
    logic [7:0] busRdData;
    logic cmpAbove;
    logic converterOn;
    logic sampleHold;
    logic resultsStable;
    logic [2:0] channelSelect;
    logic [9:0] dacCode;
    int miscompares = 0;
    int checked = 0;
    int k;
    logic [7:0] d;
    logic [7:0] h;
    logic [7:0] l;

    sac_control uut (.core_clk(core_clk), .sys_rst(sys_rst), .busAddr(busAddr),
        .busWrData(busWrData), .busWrEn(busWrEn), .busRdEn(busRdEn), .busRdData(busRdData),
        .cmpAbove(cmpAbove), .deepStop(deepStop), .converterOn(converterOn),
        .channelSelect(channelSelect), .sampleHold(sampleHold), .dacCode(dacCode),
        .resultsStable(resultsStable));
    sac_analog_model analog (.core_clk(core_clk), .converterOn(converterOn),
        .channelSelect(channelSelect), .sampleHold(sampleHold), .dacCode(dacCode),
        .levels(levels), .cmpAbove(cmpAbove));

    initial forever #20 core_clk = ~core_clk;

    // ==========================================
    // Checking and bus tasks
    task automatic report_and_stop();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic fail_now(input string m);
        $display("CHECK FAILED t=%0t %s", $time, m);
        miscompares++;
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
        checked++;
        if (g !== e) fail_now(m);
    endtask
    task automatic chkn(input int g, input int lo, input int hi, input string m);
        checked++;
        if (g < lo || g > hi) fail_now(m);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge core_clk);
        busAddr <= a;
        busWrData <= v;
        busWrEn <= 1'b1;
        @(posedge core_clk);
        busWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge core_clk);
        busAddr <= a;
        busRdEn <= 1'b1;
        @(posedge core_clk);
        busRdEn <= 1'b0;
        #1 v = busRdData;
    endtask
    task automatic wait_done();
        for (int n = 0; n < 3000; n++) begin
            rd(OFF_CONTROL_STATUS, d);
            if (d[CSR_DONE_BIT] === 1'b1) return;
        end
        fail_now("no end of conversion");
        report_and_stop();
    endtask
    task automatic wait_hold(input logic v);
        for (int n = 0; n < 2000; n++) begin
            @(posedge core_clk);
            #1;
            if (sampleHold === v) return;
        end
        fail_now("sample phase missing");
        report_and_stop();
    endtask

    // ==========================================
    // One conversion against the reference model
    task automatic convert(input int chan, input int lv, input logic [1:0] s);
        int div;
        int e;
        logic [9:0] c;
        div = (s == SEL_FULL) ? 1 : (s == SEL_QUARTER) ? 4 : 2;
        e = (lv > 1023) ? 1023 : lv;
        @(posedge core_clk);
        levels[chan * 11 +: 11] <= 11'(lv);
        wr(OFF_CONTROL_STATUS, {1'b0, s[0], 1'b0, s[1], 1'b0, 3'(chan)});
        wr(OFF_CONTROL_STATUS, {1'b0, s[0], 1'b1, s[1], 1'b0, 3'(chan)});
        wait_hold(1'b1);
        chk8({5'h00, channelSelect}, 8'(chan), "mux select");
        wait_hold(1'b0);
        for (int i = 0; i < 2; i++) begin
            c = dacCode;
            for (k = 0; k < 100 && dacCode === c; k++) begin
                @(posedge core_clk);
                #1;
            end
        end
        chkn(k, 6 * div, 6 * div, "bit step length");
        wait_done();
        rd(OFF_RESULT_LOW, l);
        rd(OFF_RESULT_HIGH, h);
        chk8(l, {6'h00, 2'(e)}, "low result");
        chk8(h, 8'(e >> 2), "high result");
        rd(OFF_CONTROL_STATUS, d);
        chk8(d[7:0] & 8'h80, 8'h00, "done after high read");
    endtask

    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(72389));
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(OFF_CONTROL_STATUS, d);
        chk8(d, CSR_RESET, "csr reset");
        rd(OFF_RESULT_HIGH, d);
        chk8(d, 8'h00, "high reset");
        rd(OFF_RESULT_LOW, d);
        chk8(d, 8'h00, "low reset");
        rd(16'h0072, d);
        chk8(d, READ_UNMAPPED, "unmapped read");
        wr(OFF_RESULT_HIGH, 8'hA5);
        rd(OFF_RESULT_HIGH, d);
        chk8(d, 8'h00, "high is read-only");
        wr(OFF_CONTROL_STATUS, 8'hDF);
        rd(OFF_CONTROL_STATUS, d);
        chk8(d, 8'h57, "csr writable bits");
        for (int i = 0; i < 8; i++) begin
            convert(i % 6, int'($urandom % 1024), 2'(i));
        end
        convert(5, 2047, SEL_FULL);
        convert(0, 0, SEL_FULL);
        // Lock: low read freezes high against new results
        @(posedge core_clk);
        levels[10:0] <= 11'h3FF;
        repeat (200) @(posedge core_clk);
        rd(OFF_RESULT_LOW, d);
        chk8(d, 8'h03, "low before lock");
        @(posedge core_clk);
        levels[10:0] <= 11'h000;
        repeat (300) @(posedge core_clk);
        rd(OFF_RESULT_LOW, d);
        chk8(d, 8'h00, "low while locked");
        rd(OFF_RESULT_HIGH, d);
        chk8(d, 8'hFF, "frozen high");
        repeat (300) @(posedge core_clk);
        rd(OFF_RESULT_HIGH, d);
        chk8(d, 8'h00, "high after unlock");
        wait_done();
        wr(OFF_CONTROL_STATUS, 8'h60);
        rd(OFF_CONTROL_STATUS, d);
        chk8(d, 8'h60, "done cleared by write");
        wr(OFF_CONTROL_STATUS, 8'h40);
        repeat (3) @(posedge core_clk);
        #1 chk8({6'h00, converterOn, sampleHold}, 8'h00, "converter off");
        repeat (300) @(posedge core_clk);
        rd(OFF_CONTROL_STATUS, d);
        chk8(d, 8'h40, "no conversion while off");
        wr(OFF_CONTROL_STATUS, 8'h60);
        repeat (20) @(posedge core_clk);
        deepStop <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1 chk8({6'h00, converterOn, resultsStable}, 8'h00, "deep stop");
        @(posedge core_clk);
        deepStop <= 1'b0;
        for (k = 0; k < 1000 && resultsStable !== 1'b1; k++) begin
            @(posedge core_clk);
            #1;
        end
        chkn(k, STAB_CYCLES_INT - 2, STAB_CYCLES_INT + 2, "settling time");
        wait_done();
        report_and_stop();
    end
endmodule
